//--- common/rst_map.svh
`ifndef RST_MAP_SVH
`define RST_MAP_SVH

// ----------------------------------------------------------------
// io register offsets
// ----------------------------------------------------------------
`define WDOG_RESTART_ADDR 8'h26
`define PSC_ADDR          8'hFF

// ----------------------------------------------------------------
// processor status/control fields
// ----------------------------------------------------------------
`define PSC_RUN_BIT  0
`define PSC_IES_BIT  2
`define PSC_SUSP_BIT 3
`define PSC_POR_BIT  4
`define PSC_WDR_BIT  6
`define PSC_POR_VAL  8'h10
`define PSC_WDR_VAL  8'h41
`define PSC_KEEP_WDR 8'h10
`define PSC_WR_MASK  8'h0C

// ----------------------------------------------------------------
// vectors and pointer reset values
// ----------------------------------------------------------------
`define RESET_VECTOR 14'h0000
`define STACK_INIT   8'h00

// ----------------------------------------------------------------
// timing, clock in MHz, times in microseconds
// ----------------------------------------------------------------
`define MCLK_MHZ  250
`define T_LOCK_US 1000
`define T_HOLD_US 95000
`define T_WDOG_US 8000
`define T_WDR_US  2000

`endif

//--- common/rst_pkg.sv
package rst_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	localparam int CNT_W = 25;

	typedef logic [7:0]       byte_t;
	typedef logic [13:0]      paddr_t;
	typedef logic [CNT_W-1:0] count_t;

	typedef enum logic [2:0] {
		PH_POR,
		PH_LOCK,
		PH_HOLD,
		PH_WDR,
		PH_RUN,
		PH_SUSP
	} phase_t;

endpackage : rst_pkg

//--- common/tmr_if.sv
`timescale 1ns/1ps

interface tmr_if;
	import rst_pkg::*;

	logic   clear;
	logic   run;
	count_t limit;
	logic   expired;

	modport ctrl (output clear, output run, output limit, input expired);
	modport tmr  (input clear, input run, input limit, output expired);

endinterface : tmr_if

//--- src/interval_timer.sv
`timescale 1ns/1ps

// one-shot interval: expired rises after limit counted cycles and holds
module interval_timer (
	input  wire logic mclk,
	input  wire logic resetn,
	tmr_if.tmr        t
);
	import rst_pkg::*;

	typedef struct packed {
		count_t cnt;
		logic   expired;
	} it_state_t;

	it_state_t s_q;
	it_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (t.clear) begin
			s_d = '0;
		end else if (t.run && !s_q.expired) begin
			if (s_q.cnt == t.limit - count_t'(1)) begin
				s_d.expired = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + count_t'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign t.expired = s_q.expired;

endmodule : interval_timer

//--- src/watchdog_timer.sv
`timescale 1ns/1ps

// free counter that gives a one-cycle rollover pulse and starts over
module watchdog_timer (
	input  wire logic mclk,
	input  wire logic resetn,
	tmr_if.tmr        t
);
	import rst_pkg::*;

	typedef struct packed {
		count_t cnt;
		logic   roll;
	} wd_state_t;

	wd_state_t s_q;
	wd_state_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.roll = 1'b0;
		if (t.clear) begin
			s_d.cnt = '0;
		end else if (t.run) begin
			if (s_q.cnt == t.limit - count_t'(1)) begin
				s_d.cnt  = '0;
				s_d.roll = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + count_t'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign t.expired = s_q.roll;

endmodule : watchdog_timer

//--- src/reset_watchdog_suspend_ctrl.sv
`timescale 1ns/1ps
`include "rst_map.svh"

// What this block does
// - any reset restores defaults, address, interrupts off
// - both resets zero program and data stacks
// - status register records power-on and watchdog causes
// - fetch starts at address zero after reset
// - reset entry pushes nothing onto stack
// - power-on reset holds core, rest runs
// - supply and oscillator good start hold timer
// - 1 ms locked, then 95 ms hold-off
// - bus reset cuts hold-off, interrupt stays pending
// - supply drop reasserts power-on reset, sequence repeats
// - any write to restart register clears watchdog
// - watchdog rollover after 8 ms gives reset
// - watchdog reset loads status pattern 010X0001
// - watchdog reset lasts 2 ms then restarts
// - suspend bit puts device into low power
// - suspend stops oscillator, pll, timers, watchdog
module reset_watchdog_suspend_ctrl #(
	parameter rst_pkg::count_t LOCK_CYC =
		rst_pkg::count_t'(`T_LOCK_US * `MCLK_MHZ),
	parameter rst_pkg::count_t HOLD_CYC =
		rst_pkg::count_t'(`T_HOLD_US * `MCLK_MHZ),
	parameter rst_pkg::count_t WDOG_CYC =
		rst_pkg::count_t'(`T_WDOG_US * `MCLK_MHZ),
	parameter rst_pkg::count_t WDR_CYC =
		rst_pkg::count_t'(`T_WDR_US * `MCLK_MHZ)
) (
	input  wire logic            mclk,
	input  wire logic            resetn,
	// supply monitor and oscillator
	input  wire logic            supply_ok,
	input  wire logic            osc_stable,
	// upstream usb and wake sources
	input  wire logic            usb_bus_reset,
	input  wire logic            usb_activity,
	input  wire logic            gpio_wake_irq,
	input  wire logic            bus_reset_irq_taken,
	// io register port of the core
	input  wire rst_pkg::byte_t  io_addr,
	input  wire rst_pkg::byte_t  io_wdata,
	input  wire logic            io_wr,
	input  wire logic            io_rd,
	output rst_pkg::byte_t       io_rdata,
	// reset and run control toward the rest of the chip
	output logic                 core_hold,
	output logic                 core_run,
	output logic                 semi_suspend,
	output logic                 regs_default,
	output logic                 usb_addr_clear,
	output logic                 int_disable,
	output logic                 fetch_start,
	output rst_pkg::paddr_t      fetch_addr,
	output rst_pkg::byte_t       program_stack_pointer,
	output rst_pkg::byte_t       data_stack_pointer,
	output logic                 bus_reset_pending,
	output logic                 watchdog_reset_event,
	output logic                 clocks_run,
	output logic                 suspended
);
	import rst_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		phase_t phase;
		byte_t  psc;
		byte_t  rdata;
		logic   bus_rst_pend;
		logic   fetch_go;
		logic   wdr_pulse;
	} ctl_state_t;

	ctl_state_t s_q;
	ctl_state_t s_d;

	tmr_if hold_t ();
	tmr_if wdog_t ();

	// ----------------------------------------------------------------
	// timers
	// ----------------------------------------------------------------
	interval_timer u_hold (
		.mclk   (mclk),
		.resetn (resetn),
		.t      (hold_t)
	);

	watchdog_timer u_wdog (
		.mclk   (mclk),
		.resetn (resetn),
		.t      (wdog_t)
	);

	logic wr_psc;
	logic wr_wdog;
	logic rd_psc;
	logic in_reset;

	assign wr_psc   = io_wr && (io_addr == `PSC_ADDR) && core_run;
	assign wr_wdog  = io_wr && (io_addr == `WDOG_RESTART_ADDR);
	assign rd_psc   = io_rd && (io_addr == `PSC_ADDR);
	assign in_reset = (s_q.phase != PH_RUN) && (s_q.phase != PH_SUSP);

	// hold timer limit follows the phase it times
	always_comb begin
		case (s_q.phase)
			PH_LOCK: hold_t.limit = LOCK_CYC;
			PH_HOLD: hold_t.limit = HOLD_CYC;
			PH_WDR:  hold_t.limit = WDR_CYC;
			default: hold_t.limit = LOCK_CYC;
		endcase
	end

	// a fresh interval on every phase change so the old expiry never leaks
	assign hold_t.clear = (s_d.phase != s_q.phase)
		|| (s_q.phase == PH_POR);
	assign hold_t.run   = (s_q.phase == PH_LOCK)
		|| (s_q.phase == PH_HOLD)
		|| (s_q.phase == PH_WDR);

	// the counter holds its value through suspend, it is only stopped
	assign wdog_t.limit = WDOG_CYC;
	assign wdog_t.run   = (s_q.phase == PH_RUN);
	assign wdog_t.clear = wr_wdog || in_reset;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb begin
		s_d           = s_q;
		s_d.fetch_go  = 1'b0;
		s_d.wdr_pulse = 1'b0;
		s_d.rdata     = '0;

		// firmware writes: steering bits, cause bits clear on a zero
		if (wr_psc) begin
			s_d.psc = (s_q.psc & ~`PSC_WR_MASK) | (io_wdata & `PSC_WR_MASK);
			if (!io_wdata[`PSC_POR_BIT]) begin
				s_d.psc[`PSC_POR_BIT] = 1'b0;
			end
			if (!io_wdata[`PSC_WDR_BIT]) begin
				s_d.psc[`PSC_WDR_BIT] = 1'b0;
			end
		end

		// pending bus reset interrupt; a new set beats the take
		if (bus_reset_irq_taken) begin
			s_d.bus_rst_pend = 1'b0;
		end

		case (s_q.phase)
			PH_POR: begin
				// core held while oscillator and other logic run
				if (supply_ok && osc_stable) begin
					s_d.phase = PH_LOCK;
				end
			end
			PH_LOCK: begin
				// bus reset is not looked at in the first stretch
				if (hold_t.expired) begin
					s_d.phase = PH_HOLD;
				end
			end
			PH_HOLD: begin
				if (usb_bus_reset) begin
					s_d.phase        = PH_RUN;
					s_d.fetch_go     = 1'b1;
					s_d.bus_rst_pend = 1'b1;
				end else if (hold_t.expired) begin
					s_d.phase    = PH_RUN;
					s_d.fetch_go = 1'b1;
				end
			end
			PH_WDR: begin
				if (hold_t.expired) begin
					s_d.phase    = PH_RUN;
					s_d.fetch_go = 1'b1;
				end
			end
			PH_RUN: begin
				if (wdog_t.expired) begin
					s_d.phase     = PH_WDR;
					s_d.wdr_pulse = 1'b1;
					// power-on cause survives, the rest is the pattern
					s_d.psc = `PSC_WDR_VAL
						| (s_q.psc & `PSC_KEEP_WDR);
					s_d.bus_rst_pend = 1'b0;
				end else if (wr_psc && io_wdata[`PSC_SUSP_BIT]) begin
					s_d.phase = PH_SUSP;
				end
			end
			PH_SUSP: begin
				// besides a supply drop, only these two sources can restart the oscillator
				if (gpio_wake_irq || usb_activity) begin
					s_d.phase               = PH_RUN;
					s_d.psc[`PSC_SUSP_BIT]  = 1'b0;
				end
			end
			default: begin
				s_d.phase = PH_POR;
			end
		endcase

		// supply loss wins over everything and starts over
		if (!supply_ok) begin
			s_d.phase        = PH_POR;
			s_d.psc          = `PSC_POR_VAL;
			s_d.bus_rst_pend = 1'b0;
			s_d.fetch_go     = 1'b0;
			s_d.wdr_pulse    = 1'b0;
		end

		// registered read data; restart register reads back zero
		if (rd_psc) begin
			s_d.rdata                = s_q.psc;
			s_d.rdata[`PSC_RUN_BIT]  = core_run;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_q.phase        <= PH_POR;
			s_q.psc          <= `PSC_POR_VAL;
			s_q.rdata        <= '0;
			s_q.bus_rst_pend <= 1'b0;
			s_q.fetch_go     <= 1'b0;
			s_q.wdr_pulse    <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign core_hold      = in_reset;
	assign core_run       = (s_q.phase == PH_RUN);
	assign semi_suspend   = (s_q.phase == PH_POR)
		|| (s_q.phase == PH_LOCK)
		|| (s_q.phase == PH_HOLD);
	assign regs_default   = in_reset;
	assign usb_addr_clear = in_reset;
	assign int_disable    = in_reset;

	// the vector is loaded straight, no return frame is written
	assign fetch_start = s_q.fetch_go;
	assign fetch_addr  = `RESET_VECTOR;

	// pointers sit at their reset value while the core is held
	assign program_stack_pointer = `STACK_INIT;
	assign data_stack_pointer    = `STACK_INIT;

	// interrupt waits here until firmware enables it
	assign bus_reset_pending    = s_q.bus_rst_pend;
	assign watchdog_reset_event = s_q.wdr_pulse;

	// suspend gates oscillator, pll and both timers
	assign clocks_run = (s_q.phase != PH_SUSP);
	assign suspended  = (s_q.phase == PH_SUSP);

	assign io_rdata = s_q.rdata;

endmodule : reset_watchdog_suspend_ctrl

//--- sim/rst_properties.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker for the reset, watchdog and suspend sequencer
// ----------------------------------------------------------------
module rst_properties #(
	parameter rst_pkg::count_t LOCK_CYC = 4,
	parameter rst_pkg::count_t HOLD_CYC = 8,
	parameter rst_pkg::count_t WDOG_CYC = 20,
	parameter rst_pkg::count_t WDR_CYC  = 4
) (
	input wire logic            mclk,
	input wire logic            resetn,
	input wire logic            supply_ok,
	input wire logic            usb_activity,
	input wire logic            gpio_wake_irq,
	input wire rst_pkg::byte_t  io_addr,
	input wire logic            io_rd,
	input wire rst_pkg::byte_t  io_rdata,
	input wire logic            core_hold,
	input wire logic            core_run,
	input wire logic            semi_suspend,
	input wire logic            regs_default,
	input wire logic            usb_addr_clear,
	input wire logic            int_disable,
	input wire logic            fetch_start,
	input wire rst_pkg::paddr_t fetch_addr,
	input wire rst_pkg::byte_t  program_stack_pointer,
	input wire rst_pkg::byte_t  data_stack_pointer,
	input wire logic            bus_reset_pending,
	input wire logic            watchdog_reset_event,
	input wire logic            clocks_run,
	input wire logic            suspended
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_defaults_held: assert property (core_hold |-> regs_default &&
		usb_addr_clear && int_disable) else $error("defaults not held");
	a_stacks_zero: assert property (core_hold |->
		program_stack_pointer == 8'h00 && data_stack_pointer == 8'h00)
		else $error("stack load not zero");
	a_fetch_vector: assert property (fetch_start |-> core_run &&
		fetch_addr == 14'h0000 && $past(core_hold)) else $error("bad fetch");
	a_semi_no_run: assert property (semi_suspend |-> !core_run)
		else $error("core runs in semi-suspend");
	a_supply_drop: assert property (!supply_ok |=> semi_suspend &&
		core_hold) else $error("supply drop ignored");
	a_bus_cut: assert property ($rose(bus_reset_pending) |->
		fetch_start && core_run) else $error("bus reset did not start");
	a_restart_wo: assert property (io_rd && io_addr == 8'h26 |=>
		io_rdata == 8'h00) else $error("restart register readable");
	a_wdr_hold: assert property (watchdog_reset_event |->
		core_hold [*4] ##[1:8] fetch_start) else $error("bad wdr span");
	a_suspend_stop: assert property (suspended |-> !clocks_run &&
		!core_run && !watchdog_reset_event) else $error("runs in suspend");
	a_wake_run: assert property (suspended &&
		(usb_activity || gpio_wake_irq) |=> core_run && !suspended)
		else $error("no wake");

	c_fetch: cover property (fetch_start);
	c_wdr: cover property (watchdog_reset_event);
	c_susp: cover property (suspended);
	c_bus: cover property ($rose(bus_reset_pending));
endmodule : rst_properties

bind reset_watchdog_suspend_ctrl rst_properties #(.LOCK_CYC(LOCK_CYC),
	.HOLD_CYC(HOLD_CYC), .WDOG_CYC(WDOG_CYC), .WDR_CYC(WDR_CYC)) u_props (
	.mclk, .resetn, .supply_ok, .usb_activity, .gpio_wake_irq, .io_addr,
	.io_rd, .io_rdata, .core_hold, .core_run, .semi_suspend, .regs_default,
	.usb_addr_clear, .int_disable, .fetch_start, .fetch_addr,
	.program_stack_pointer, .data_stack_pointer, .bus_reset_pending,
	.watchdog_reset_event, .clocks_run, .suspended);

//--- sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb_top;
	import rst_pkg::*;
	localparam count_t LOCK = 4, HOLD = 8, WDOG = 60, WDRC = 4;
	logic mclk, resetn, supply_ok, osc_stable, usb_bus_reset, usb_activity;
	logic gpio_wake_irq, bus_reset_irq_taken, io_wr, io_rd;
	byte_t io_addr, io_wdata, io_rdata, program_stack_pointer;
	byte_t data_stack_pointer;
	paddr_t fetch_addr;
	logic core_hold, core_run, semi_suspend, regs_default, usb_addr_clear;
	logic int_disable, fetch_start, bus_reset_pending, watchdog_reset_event;
	logic clocks_run, suspended;
	integer failures = 0, n_tests = 0, seed = 32'h559EAF65, n, wdr_cnt = 0;
	byte_t d;

	reset_watchdog_suspend_ctrl #(.LOCK_CYC(LOCK), .HOLD_CYC(HOLD),
		.WDOG_CYC(WDOG), .WDR_CYC(WDRC)) u_dut (.mclk, .resetn, .supply_ok,
		.osc_stable, .usb_bus_reset, .usb_activity, .gpio_wake_irq,
		.bus_reset_irq_taken, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
		.core_hold, .core_run, .semi_suspend, .regs_default, .usb_addr_clear,
		.int_disable, .fetch_start, .fetch_addr, .program_stack_pointer,
		.data_stack_pointer, .bus_reset_pending, .watchdog_reset_event,
		.clocks_run, .suspended);

	// ----------------------------------------------------------------
	// helpers; timing windows allow a few cycles of timer overhead
	// ----------------------------------------------------------------
	function automatic bit in_win(int got, int base);
		return got >= base && got <= base + 5;
	endfunction : in_win
	task automatic wr(byte_t a, byte_t v);
		@(posedge mclk);
		io_addr <= a;
		io_wdata <= v;
		io_wr <= 1'b1;
		@(posedge mclk);
		io_wr <= 1'b0;
	endtask : wr
	task automatic rd(byte_t a, byte_t e);
		@(posedge mclk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge mclk);
		io_rd <= 1'b0;
		@(negedge mclk);
		`CHK(io_rdata, e)
	endtask : rd
	task automatic wait_ev(bit wd, output int k);
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (!(wd ? watchdog_reset_event : fetch_start) && k < 400);
		if (k >= 400) begin
			failures++;
			$display("[FAIL] %0t wait timed out", $time);
		end
	endtask : wait_ev
	task automatic report_and_stop;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) if (watchdog_reset_event) wdr_cnt++;
	initial begin
		#(4 * 5000);
		failures++;
		report_and_stop();
	end

	initial begin
		{resetn, osc_stable, usb_bus_reset, usb_activity, io_wr, io_rd} = '0;
		{gpio_wake_irq, bus_reset_irq_taken, io_addr, io_wdata} = '0;
		supply_ok = 1'b1;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		repeat (10) @(posedge mclk);
		@(negedge mclk);
		`CHK({semi_suspend, core_hold, core_run}, 3'b110)
		`CHK({program_stack_pointer, data_stack_pointer}, 16'h0000)
		`CHK({regs_default, usb_addr_clear, int_disable}, 3'b111)
		@(posedge mclk);
		osc_stable <= 1'b1;
		usb_bus_reset <= 1'b1;
		repeat (3) @(posedge mclk);
		usb_bus_reset <= 1'b0;
		wait_ev(0, n);
		`CHK(in_win(n + 3, LOCK + HOLD), 1'b1)
		`CHK(fetch_addr, 14'h0000)
		`CHK(bus_reset_pending, 1'b0)
		rd(8'hFF, 8'h11);
		wr(8'hFF, 8'h00);
		rd(8'hFF, 8'h01);
		repeat (3) begin
			d = byte_t'($random(seed));
			wr(8'hFF, d & 8'hA7);
			rd(8'hFF, 8'h01 | (d & 8'h04));
		end
		rd(8'h40 | byte_t'($random(seed) & 32'h3F), 8'h00);
		rd(8'h26, 8'h00);
		$display("registers done");
		repeat (4) begin
			wr(8'h26, byte_t'($random(seed)));
			repeat (WDOG - 8) @(posedge mclk);
		end
		`CHK(wdr_cnt, 0)
		wait_ev(1, n);
		`CHK(in_win(n + WDOG - 8, WDOG), 1'b1)
		`CHK(core_hold, 1'b1)
		wait_ev(0, n);
		`CHK(in_win(n, WDRC), 1'b1)
		rd(8'hFF, 8'h41);
		wait_ev(1, n);
		`CHK(in_win(n + 4, WDOG), 1'b1)
		wait_ev(0, n);
		$display("watchdog done");
		for (int i = 0; i < 2; i++) begin
			wr(8'h26, 8'h00);
			wr(8'hFF, 8'h08);
			@(negedge mclk);
			`CHK({suspended, clocks_run}, 2'b10)
			n = wdr_cnt;
			repeat (WDOG + 10) @(posedge mclk);
			@(negedge mclk);
			`CHK(wdr_cnt, n)
			`CHK(suspended, 1'b1)
			@(posedge mclk);
			if (i == 0) gpio_wake_irq <= 1'b1;
			else usb_activity <= 1'b1;
			@(posedge mclk);
			{gpio_wake_irq, usb_activity} <= 2'b00;
			@(negedge mclk);
			`CHK({core_run, clocks_run}, 2'b11)
			rd(8'hFF, 8'h01);
		end
		// a counter left running in suspend would roll early here
		wait_ev(1, n);
		`CHK(in_win(n + 3, WDOG), 1'b1)
		wait_ev(0, n);
		$display("suspend done");
		@(posedge mclk);
		supply_ok <= 1'b0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		`CHK({semi_suspend, core_hold}, 2'b11)
		@(posedge mclk);
		supply_ok <= 1'b1;
		repeat (LOCK + 4) @(posedge mclk);
		@(negedge mclk);
		`CHK(core_run, 1'b0)
		@(posedge mclk);
		usb_bus_reset <= 1'b1;
		@(posedge mclk);
		usb_bus_reset <= 1'b0;
		@(negedge mclk);
		`CHK({core_run, fetch_start, bus_reset_pending}, 3'b111)
		rd(8'hFF, 8'h11);
		`CHK(bus_reset_pending, 1'b1)
		@(posedge mclk);
		bus_reset_irq_taken <= 1'b1;
		@(posedge mclk);
		bus_reset_irq_taken <= 1'b0;
		@(negedge mclk);
		`CHK(bus_reset_pending, 1'b0)
		$display("bus reset done");
		report_and_stop();
	end
endmodule : tb_top
